/* File: src/ccp_consts.svh */
// Purpose: Offsets, field positions and reset values of the capture unit
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes: Included by the unit and by the bench
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH
`define CCP_OFF_CONTROL 12'h000
`define CCP_OFF_CAPSRC 12'h004
`define CCP_OFF_VAL_LO 12'h008
`define CCP_OFF_VAL_HI 12'h00C
`define CCP_OFF_TBSEL 12'h010
`define CCP_OFF_PERIOD 12'h014
`define CCP_OFF_PRESCALE 12'h018
`define CCP_OFF_STATUS 12'h01C
`define CCP_BIT_EN 7
`define CCP_BIT_OUT 5
`define CCP_BIT_FMT 4
`define CCP_BIT_TB1 0
`define CCP_BIT_TB2 2
`define CCP_PRE_LAST_1 4'h0
`define CCP_PRE_LAST_4 4'h3
`define CCP_PRE_LAST_16 4'hF
`define CCP_RST_CONTROL 8'h00
`define CCP_RST_CAPSRC 3'h0
`define CCP_RST_VALUE 8'h00
`define CCP_RST_TBSEL 8'h05
`define CCP_RST_PERIOD 8'hFF
`define CCP_RST_PRESCALE 2'h0
`define CCP_RESP_OKAY 2'h0
`define CCP_RESP_DECERR 2'h3
`define CCP_OSC_PER_STEP 4
`endif

/* File: src/ccp_pkg.sv */
// Purpose: Types of the capture/compare/PWM unit
// Assumes: Constants come from ccp_consts.svh
// Notes: Mode codes follow the control register's low nibble
package ccp_pkg;
  typedef enum logic [3:0] {
    CCP_OFF = 4'h0,
    CCP_CMP_TGL_CLR = 4'h1,
    CCP_CMP_TGL = 4'h2,
    CCP_CAP_BOTH = 4'h3,
    CCP_CAP_FALL = 4'h4,
    CCP_CAP_RISE = 4'h5,
    CCP_CAP_RISE4 = 4'h6,
    CCP_CAP_RISE16 = 4'h7,
    CCP_CMP_SET = 4'h8,
    CCP_CMP_CLR = 4'h9,
    CCP_CMP_PULSE = 4'hA,
    CCP_CMP_PULSE_CLR = 4'hB,
    CCP_RSV_C = 4'hC,
    CCP_RSV_D = 4'hD,
    CCP_RSV_E = 4'hE,
    CCP_PWM = 4'hF
  } ccp_mode_e;
  typedef struct packed {
    logic unit_enable;
    logic duty_alignment;
    ccp_mode_e unit_mode_select;
  } ccp_ctrl_s;
  typedef struct packed {
    logic [7:0] value_high;
    logic [7:0] value_low;
  } ccp_value_s;
endpackage : ccp_pkg

/* File: src/ccp_unit.sv */
// Purpose: Capture/compare/PWM unit with period timer and AXI4-Lite slave
// Assumes: 250 MHz I_MCLK, sync active-high reset, timers given as inputs
// Notes: Outputs are registered; I_SLEEP freezes timer, capture and compare, but bus writes still update registers
// Operation
// - PWM period is (period_limit+1) times four oscillator steps times prescale.
// - After timer equals limit: clear timer, set pin unless 0%, load duty.
// - Postscaler does not affect PWM period.
// - Ten-bit duty taken from value pair, aligned by format bit.
// - Value pair writable anytime; duty takes effect at next period match.
// - Time base is period timer extended with two low phase/prescale bits.
// - Time base equal to buffered duty clears the PWM pin.
// - Resolution is log2 of four times limit plus one, ten bits max.
// - Duty beyond period never matches, pin stays unchanged that period.
// - Sleep stops timer and holds all state and pin level; here bus writes still update registers during sleep.
// - Reset returns registers to defaults and sets pin to input.
// - Control bit7 enable, bit6 reads zero, bit5 shows output.
// - Format bit4 selects right or left alignment in PWM only.
// - Mode 1111 is PWM, 1100-1110 reserved, 0000 turns unit off.
// - Compare modes pulse, clear, set, toggle, some clear capture timer.
// - Capture on 16th, 4th, every rising, falling, or every edge.
// - Every mode sets event flag and pulses ADC trigger if selected.
// - Three-bit source field selects pin, comparators, osc, change, cells.
// - Capture loads timer bytes into pair; compare checks pair against timer.
// - Format 0: low byte LSBs, high 1:0 MSBs; format 1 high MSBs, low 7:6.
// - Time base bits 0 and 2 pick alt timer at 0, capture timer at 1.
// - Cleared control forces compare output latch low.
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "ccp_consts.svh"
module ccp_unit #(
  parameter int ADDR_W = 12,
  parameter int UNIT_IDX = 1
) (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_SLEEP,
  input wire logic [15:0] I_CAPTURE_TIMER,
  input wire logic [15:0] I_ALT_TIMER,
  input wire logic [7:0] I_CAP_SOURCES,
  input wire logic I_ADC_SRC_SEL,
  output logic O_UNIT_PIN,
  output logic O_UNIT_PIN_OE_N,
  output logic O_CAP_TIMER_CLEAR,
  output logic O_ADC_TRIGGER,
  output logic O_EVENT
);
  if (ADDR_W < 5 || (UNIT_IDX != 1 && UNIT_IDX != 2))
  begin : gen_bad_params
    $error("ccp_unit: unsupported parameters");
  end

  ccp_pkg::ccp_ctrl_s ctrl_r;
  logic [2:0] capsrc_r;
  ccp_pkg::ccp_value_s val_r;
  logic [7:0] tbsel_r;
  logic [7:0] period_limit_r;
  logic [1:0] prescale_r;
  logic [7:0] period_timer_r;
  logic [3:0] pre_cnt_r;
  logic [1:0] phase_r;
  logic [9:0] duty_buf_r;
  logic out_r;
  logic flag_r;
  logic [2:0] sync_r;
  logic src_prev_r;
  logic [3:0] cap_pre_r;
  logic pulse_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;

  logic active;
  logic is_pwm;
  logic is_cap;
  logic is_cmp;
  logic tick;
  logic step;
  logic period_match;
  logic [9:0] time_base;
  logic [9:0] time_base_nxt;
  logic [9:0] duty_new;
  logic [15:0] cmp_timer;
  logic cmp_hit;
  logic rise;
  logic fall;
  logic cap_hit;
  logic event_now;
  logic wr_go;
  logic [31:0] rd_mux;
  logic [2:0] tb_bit;

  assign active = ctrl_r.unit_enable && !I_SLEEP;
  assign is_pwm = ctrl_r.unit_mode_select == ccp_pkg::CCP_PWM;
  assign is_cap = ctrl_r.unit_mode_select inside
    {[ccp_pkg::CCP_CAP_BOTH:ccp_pkg::CCP_CAP_RISE16]};
  assign is_cmp = ctrl_r.unit_mode_select inside
    {ccp_pkg::CCP_CMP_TGL_CLR, ccp_pkg::CCP_CMP_TGL,
     [ccp_pkg::CCP_CMP_SET:ccp_pkg::CCP_CMP_PULSE_CLR]};

  // One time-base step per prescaled clock; four steps per timer increment
  assign tick = pre_cnt_r == ((prescale_r == 2'h0) ? `CCP_PRE_LAST_1
    : (prescale_r == 2'h1) ? `CCP_PRE_LAST_4 : `CCP_PRE_LAST_16);
  assign step = active && is_pwm && tick;
  assign period_match = step && phase_r == 2'(`CCP_OSC_PER_STEP - 1)
    && period_timer_r == period_limit_r;
  // Phase steps once per prescaled clock as a two-bit counter of its own,
  // separate from the prescaler count, at every prescale setting
  assign time_base = {period_timer_r, phase_r};
  assign time_base_nxt = time_base + 10'h001;
  assign duty_new = ctrl_r.duty_alignment
    ? {val_r.value_high, val_r.value_low[7:6]}
    : {val_r.value_high[1:0], val_r.value_low};

  assign tb_bit = (UNIT_IDX == 1) ? 3'(`CCP_BIT_TB1) : 3'(`CCP_BIT_TB2);
  assign cmp_timer = tbsel_r[tb_bit] ? I_CAPTURE_TIMER
    : I_ALT_TIMER;
  assign cmp_hit = active && is_cmp && !pulse_r
    && cmp_timer[15:8] == val_r.value_high
    && cmp_timer[7:0] == val_r.value_low;

  assign rise = sync_r[1] && sync_r[2] && !src_prev_r;
  assign fall = !sync_r[1] && !sync_r[2] && src_prev_r;
  always_comb
  begin
    cap_hit = 1'b0;
    unique case (ctrl_r.unit_mode_select)
      ccp_pkg::CCP_CAP_BOTH: cap_hit = rise || fall;
      ccp_pkg::CCP_CAP_FALL: cap_hit = fall;
      ccp_pkg::CCP_CAP_RISE: cap_hit = rise;
      ccp_pkg::CCP_CAP_RISE4: cap_hit = rise && cap_pre_r[1:0] == 2'h3;
      ccp_pkg::CCP_CAP_RISE16: cap_hit = rise && cap_pre_r == 4'hF;
      default: cap_hit = 1'b0;
    endcase
    cap_hit = cap_hit && active;
  end
  assign event_now = cap_hit || cmp_hit || period_match;

  // Source pin through three flops; edge counts once last two agree
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
      sync_r <= 3'h0;
    else
      sync_r <= {sync_r[1:0], I_CAP_SOURCES[capsrc_r]};
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
      src_prev_r <= 1'b0;
    else if (sync_r[1] == sync_r[2])
      src_prev_r <= sync_r[2];
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET || !ctrl_r.unit_enable || !is_cap)
      cap_pre_r <= 4'h0;
    else if (active && rise)
      cap_pre_r <= cap_pre_r + 4'h1;
  end

  // Period timer, prescaler and phase
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET || !ctrl_r.unit_enable || !is_pwm)
    begin
      pre_cnt_r <= 4'h0;
      phase_r <= 2'h0;
      period_timer_r <= 8'h00;
    end
    else if (active)
    begin
      pre_cnt_r <= tick ? 4'h0 : pre_cnt_r + 4'h1;
      if (step)
      begin
        phase_r <= phase_r + 2'h1;
        if (period_match)
          period_timer_r <= 8'h00;
        else if (phase_r == 2'(`CCP_OSC_PER_STEP - 1))
          period_timer_r <= period_timer_r + 8'h01;
      end
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET || !ctrl_r.unit_enable)
      duty_buf_r <= 10'h000;
    else if (period_match)
      duty_buf_r <= duty_new;
  end

  // Output latch
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET || !ctrl_r.unit_enable)
      out_r <= 1'b0;
    else if (period_match)
      out_r <= duty_new != 10'h000;
    else if (step && time_base_nxt == duty_buf_r)
      out_r <= 1'b0;
    else if (cmp_hit)
    begin
      unique case (ctrl_r.unit_mode_select)
        ccp_pkg::CCP_CMP_SET: out_r <= 1'b1;
        ccp_pkg::CCP_CMP_CLR: out_r <= 1'b0;
        ccp_pkg::CCP_CMP_PULSE, ccp_pkg::CCP_CMP_PULSE_CLR: out_r <= 1'b1;
        default: out_r <= !out_r;
      endcase
    end
    else if (pulse_r)
      out_r <= 1'b0;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
      pulse_r <= 1'b0;
    else
      pulse_r <= cmp_hit && (ctrl_r.unit_mode_select
        inside {ccp_pkg::CCP_CMP_PULSE, ccp_pkg::CCP_CMP_PULSE_CLR});
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      O_UNIT_PIN <= 1'b0;
      O_UNIT_PIN_OE_N <= 1'b1;
      O_CAP_TIMER_CLEAR <= 1'b0;
      O_ADC_TRIGGER <= 1'b0;
      O_EVENT <= 1'b0;
    end
    else
    begin
      O_UNIT_PIN <= out_r;
      O_UNIT_PIN_OE_N <= !(ctrl_r.unit_enable && (is_pwm || is_cmp));
      O_CAP_TIMER_CLEAR <= cmp_hit && (ctrl_r.unit_mode_select inside
        {ccp_pkg::CCP_CMP_TGL_CLR, ccp_pkg::CCP_CMP_PULSE_CLR});
      O_ADC_TRIGGER <= event_now && I_ADC_SRC_SEL;
      O_EVENT <= event_now;
    end
  end

  // Event flag: set wins over software clear
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
      flag_r <= 1'b0;
    else if (event_now)
      flag_r <= 1'b1;
    else if (wr_go && awaddr_r == ADDR_W'(`CCP_OFF_STATUS) && wstrb_r[0]
      && wdata_r[0])
      flag_r <= 1'b0;
  end

  // AXI4-Lite write path
  assign wr_go = aw_have_r && w_have_r && !O_BVALID;
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= `CCP_RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end
    else
    begin
      O_AWREADY <= !aw_have_r && !O_AWREADY;
      O_WREADY <= !w_have_r && !O_WREADY;
      if (I_AWVALID && O_AWREADY)
      begin
        aw_have_r <= 1'b1;
        awaddr_r <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY)
      begin
        w_have_r <= 1'b1;
        wdata_r <= I_WDATA;
        wstrb_r <= I_WSTRB;
      end
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= (awaddr_r[ADDR_W-1:2] > 
          (ADDR_W-2)'(`CCP_OFF_STATUS >> 2)) || (awaddr_r[1:0] != 2'h0)
          ? `CCP_RESP_DECERR : `CCP_RESP_OKAY;
      end
      else if (O_BVALID && I_BREADY)
        O_BVALID <= 1'b0;
    end
  end

  // Register writes, also taken during sleep; captures load only while active
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      ctrl_r <= ccp_pkg::ccp_ctrl_s'(6'(`CCP_RST_CONTROL));
      capsrc_r <= `CCP_RST_CAPSRC;
      val_r <= {`CCP_RST_VALUE, `CCP_RST_VALUE};
      tbsel_r <= `CCP_RST_TBSEL;
      period_limit_r <= `CCP_RST_PERIOD;
      prescale_r <= `CCP_RST_PRESCALE;
    end
    else
    begin
      if (wr_go && wstrb_r[0])
      begin
        unique case (awaddr_r)
          ADDR_W'(`CCP_OFF_CONTROL):
            ctrl_r <= {wdata_r[`CCP_BIT_EN], wdata_r[`CCP_BIT_FMT],
              ccp_pkg::ccp_mode_e'(wdata_r[3:0])};
          ADDR_W'(`CCP_OFF_CAPSRC): capsrc_r <= wdata_r[2:0];
          ADDR_W'(`CCP_OFF_VAL_LO): val_r.value_low <= wdata_r[7:0];
          ADDR_W'(`CCP_OFF_VAL_HI): val_r.value_high <= wdata_r[7:0];
          ADDR_W'(`CCP_OFF_TBSEL):
            tbsel_r <= wdata_r[7:0] & `CCP_RST_TBSEL;
          ADDR_W'(`CCP_OFF_PERIOD): period_limit_r <= wdata_r[7:0];
          ADDR_W'(`CCP_OFF_PRESCALE): prescale_r <= wdata_r[1:0];
          default: ;
        endcase
      end
      else if (cap_hit)
        val_r <= cmp_timer;
    end
  end

  // AXI4-Lite read path
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (I_ARADDR)
      ADDR_W'(`CCP_OFF_CONTROL):
        rd_mux[7:0] = {ctrl_r.unit_enable, 1'b0, out_r,
          ctrl_r.duty_alignment, ctrl_r.unit_mode_select};
      ADDR_W'(`CCP_OFF_CAPSRC): rd_mux[2:0] = capsrc_r;
      ADDR_W'(`CCP_OFF_VAL_LO): rd_mux[7:0] = val_r.value_low;
      ADDR_W'(`CCP_OFF_VAL_HI): rd_mux[7:0] = val_r.value_high;
      ADDR_W'(`CCP_OFF_TBSEL): rd_mux[7:0] = tbsel_r;
      ADDR_W'(`CCP_OFF_PERIOD): rd_mux[7:0] = period_limit_r;
      ADDR_W'(`CCP_OFF_PRESCALE): rd_mux[1:0] = prescale_r;
      ADDR_W'(`CCP_OFF_STATUS): rd_mux[0] = flag_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= `CCP_RESP_OKAY;
    end
    else
    begin
      O_ARREADY <= !O_RVALID && !O_ARREADY && I_ARVALID;
      if (I_ARVALID && O_ARREADY)
      begin
        O_RVALID <= 1'b1;
        O_RDATA <= rd_mux;
        O_RRESP <= (I_ARADDR[ADDR_W-1:2] >
          (ADDR_W-2)'(`CCP_OFF_STATUS >> 2)) || (I_ARADDR[1:0] != 2'h0)
          ? `CCP_RESP_DECERR : `CCP_RESP_OKAY;
      end
      else if (O_RVALID && I_RREADY)
        O_RVALID <= 1'b0;
    end
  end
endmodule : ccp_unit

/* File: tb/ccp_unit_asserts.sv */
// Purpose: Port-level checks of the capture/compare/PWM unit
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound into every ccp_unit instance
`timescale 1ns/100ps
module ccp_unit_asserts (
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_SLEEP,
  input wire logic I_ADC_SRC_SEL,
  input wire logic I_AWVALID,
  input wire logic I_WVALID,
  input wire logic I_ARVALID,
  input wire logic O_AWREADY,
  input wire logic O_WREADY,
  input wire logic O_ARREADY,
  input wire logic O_BVALID,
  input wire logic O_RVALID,
  input wire logic O_UNIT_PIN,
  input wire logic O_UNIT_PIN_OE_N,
  input wire logic O_EVENT,
  input wire logic O_ADC_TRIGGER,
  input wire logic O_CAP_TIMER_CLEAR
);
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RESET);
  sequence wr_taken_s;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence resp_late_s;
    !O_BVALID ##1 O_BVALID;
  endsequence
  sequence sleep_two_s;
    I_SLEEP ##1 I_SLEEP;
  endsequence
  reset_quiet_a: assert property (
    $past(I_RESET) |-> O_UNIT_PIN_OE_N && !O_UNIT_PIN && !O_EVENT)
    else $error("outputs active after reset");
  wr_resp_a: assert property (wr_taken_s |=> resp_late_s)
    else $error("write response not two cycles after take");
  rd_resp_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read data late");
  sleep_hold_a: assert property (
    sleep_two_s |-> $stable(O_UNIT_PIN) && $stable(O_UNIT_PIN_OE_N))
    else $error("pin moved while asleep");
  adc_pair_a: assert property (
    O_EVENT && $past(I_ADC_SRC_SEL) |-> O_ADC_TRIGGER)
    else $error("event without conversion trigger");
  adc_cause_a: assert property (O_ADC_TRIGGER |-> O_EVENT)
    else $error("trigger without event");
  tclr_event_a: assert property (
    O_CAP_TIMER_CLEAR |-> O_EVENT ##1 !O_CAP_TIMER_CLEAR)
    else $error("timer clear not a single match pulse");
  event_pulse_a: assert property (O_EVENT |=> !O_EVENT)
    else $error("event longer than one cycle");
endmodule : ccp_unit_asserts
bind ccp_unit ccp_unit_asserts chk_i (
  .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_SLEEP(I_SLEEP),
  .I_ADC_SRC_SEL(I_ADC_SRC_SEL), .I_AWVALID(I_AWVALID),
  .I_WVALID(I_WVALID), .I_ARVALID(I_ARVALID), .O_AWREADY(O_AWREADY),
  .O_WREADY(O_WREADY), .O_ARREADY(O_ARREADY), .O_BVALID(O_BVALID),
  .O_RVALID(O_RVALID), .O_UNIT_PIN(O_UNIT_PIN),
  .O_UNIT_PIN_OE_N(O_UNIT_PIN_OE_N), .O_EVENT(O_EVENT),
  .O_ADC_TRIGGER(O_ADC_TRIGGER), .O_CAP_TIMER_CLEAR(O_CAP_TIMER_CLEAR)
);

/* File: tb/ccp_far_side.sv */
// Purpose: Timers and capture inputs that surround the unit
// Assumes: Timers step on the unit's clock
// Notes: Timers wrap at WRAP so compare waits stay short
`timescale 1ns/100ps
module ccp_far_side #(
  parameter logic [15:0] WRAP = 16'h00FF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_timer_clear,
  input wire logic i_src_run,
  output logic [15:0] o_cap_timer,
  output logic [15:0] o_alt_timer,
  output logic [7:0] o_sources
);
  logic [2:0] phase_r;
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_timer_clear || o_cap_timer == WRAP)
      o_cap_timer <= 16'h0;
    else
      o_cap_timer <= o_cap_timer + 16'h1;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_alt_timer <= 16'h0040;
    else
      o_alt_timer <= (o_alt_timer == WRAP) ? 16'h0 : o_alt_timer + 16'h1;
  end
  // Inputs toggle every 8 cycles only while running
  always_ff @(posedge i_clk)
  begin
    phase_r <= (i_src_run && !i_rst) ? phase_r + 3'h1 : 3'h0;
    if (i_rst)
      o_sources <= 8'h00;
    else if (i_src_run && phase_r == 3'h7)
      o_sources <= ~o_sources;
  end
endmodule : ccp_far_side

/* File: tb/ccp_pwm_capture_compare_unit_tb.sv */
// Purpose: Self-checking bench for the capture/compare/PWM unit
// Assumes: 250 MHz clock, each bus channel held until taken
// Notes: A monitor checks bus answers against a queue of expectations
`timescale 1ns/100ps
`include "ccp_consts.svh"
module ccp_pwm_capture_compare_unit_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sleep = 1'b0;
  logic adc_sel = 1'b0;
  logic run = 1'b0;
  logic [15:0] cap_t, alt_t;
  logic [7:0] srcs;
  logic awready, wready, bvalid, arready, rvalid, pin, oe_n, tclr, adc, evt;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] q[$];
  logic [33:0] got;
  logic clr;
  logic [7:0] v;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int i, n;
  logic [3:0] cmp_mode [6] = '{4'h8, 4'h9, 4'h2, 4'h1, 4'hA, 4'hB};
  logic [5:0] cmp_pin = 6'h0D;
  logic [5:0] cmp_clr = 6'h28;
  logic [3:0] cap_mode [5] = '{4'h7, 4'h6, 4'h5, 4'h4, 4'h3};
  int cap_cnt [5] = '{2, 8, 32, 32, 64};
  logic [7:0] rst_val [8] = '{`CCP_RST_CONTROL, 8'(`CCP_RST_CAPSRC),
    `CCP_RST_VALUE, `CCP_RST_VALUE, `CCP_RST_TBSEL, `CCP_RST_PERIOD,
    8'(`CCP_RST_PRESCALE), 8'h00};
  ccp_unit dut (
    .I_MCLK(mclk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_SLEEP(sleep), .I_CAPTURE_TIMER(cap_t), .I_ALT_TIMER(alt_t),
    .I_CAP_SOURCES(srcs), .I_ADC_SRC_SEL(adc_sel), .O_UNIT_PIN(pin),
    .O_UNIT_PIN_OE_N(oe_n), .O_CAP_TIMER_CLEAR(tclr),
    .O_ADC_TRIGGER(adc), .O_EVENT(evt)
  );
  ccp_far_side far (.i_clk(mclk), .i_rst(rst), .i_timer_clear(tclr),
    .i_src_run(run), .o_cap_timer(cap_t), .o_alt_timer(alt_t),
    .o_sources(srcs));
  task automatic final_report;
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    @(posedge mclk);
    q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    q.push_back({26'h0, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // Counts high cycles over two whole periods once the duty has settled
  task automatic pwm(input logic [1:0] ps, input logic [7:0] lim,
                     input logic fmt, input logic [7:0] lo,
                     input logic [7:0] hi, input int hp);
    int per, cnt;
    per = 4 * (lim + 1) * (ps == 2'h0 ? 1 : ps == 2'h1 ? 4 : 16);
    cnt = 0;
    wr(`CCP_OFF_CONTROL, 32'h0);
    wr(`CCP_OFF_PERIOD, {24'h0, lim});
    wr(`CCP_OFF_PRESCALE, {30'h0, ps});
    wr(`CCP_OFF_VAL_LO, {24'h0, lo});
    wr(`CCP_OFF_VAL_HI, {24'h0, hi});
    wr(`CCP_OFF_CONTROL, {24'h0, 3'h4, fmt, 4'hF});
    repeat (3 * per) @(posedge mclk);
    repeat (2 * per) @(posedge mclk) cnt += (pin === 1'b1);
    chk(34'(cnt), 34'(2 * hp));
  endtask : pwm
  always @(posedge mclk)
  begin
    if ((rvalid && rready) || (bvalid && bready))
    begin
      got = rvalid ? {rresp, rdata} : {bresp, 32'h0};
      chk(got, q.pop_front());
    end
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    void'($urandom(76418));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++)
      rd(12'(i * 4), rst_val[i]);
    wr(`CCP_OFF_CONTROL, 32'h00CE);
    rd(`CCP_OFF_CONTROL, 8'h8E);
    wr(`CCP_OFF_CAPSRC, 32'h00FF);
    rd(`CCP_OFF_CAPSRC, 8'h07);
    wr(`CCP_OFF_TBSEL, 32'h00FA);
    rd(`CCP_OFF_TBSEL, 8'h00);
    wr(12'h020, 32'h0001, `CCP_RESP_DECERR);
    wr(12'h002, 32'h0001, `CCP_RESP_DECERR);
    pwm(2'h0, 8'h03, 1'b0, 8'h06, 8'h00, 6);
    sleep <= 1'b1;
    repeat (2) @(posedge mclk);
    clr = pin;
    n = 0;
    repeat (38) @(posedge mclk) n += (pin !== clr);
    sleep <= 1'b0;
    chk(34'(n), 34'h0);
    pwm(2'h1, 8'h03, 1'b1, 8'h40, 8'h01, 20);
    pwm(2'h2, 8'h03, 1'b0, 8'h03, 8'h00, 48);
    pwm(2'h0, 8'h03, 1'b0, 8'h00, 8'h00, 0);
    pwm(2'h0, 8'h03, 1'b0, 8'h14, 8'h00, 16);
    pwm(2'h0, 8'hFF, 1'b0, 8'hFF, 8'h03, 1023);
    for (i = 0; i < 6; i++)
    begin
      wr(`CCP_OFF_CONTROL, 32'h0);
      adc_sel <= 1'($urandom);
      wr(`CCP_OFF_TBSEL, {29'h0, 2'h2, 1'($urandom)});
      v = 8'($urandom_range(240, 16));
      wr(`CCP_OFF_VAL_LO, {24'h0, v});
      wr(`CCP_OFF_VAL_HI, 32'h0);
      wr(`CCP_OFF_CONTROL, {24'h0, 4'h8, cmp_mode[i]});
      do @(posedge mclk); while (evt !== 1'b1);
      clr = tclr;
      repeat (4) @(posedge mclk);
      chk({33'h0, clr}, {33'h0, cmp_clr[i]});
      chk({32'h0, pin, oe_n}, {32'h0, cmp_pin[i], 1'b0});
      rd(`CCP_OFF_CONTROL, {2'h2, cmp_pin[i], 1'b0, cmp_mode[i]});
    end
    for (i = 0; i < 5; i++)
    begin
      wr(`CCP_OFF_CONTROL, 32'h0);
      adc_sel <= 1'($urandom);
      wr(`CCP_OFF_CAPSRC, 32'($urandom_range(6, 0)));
      wr(`CCP_OFF_CONTROL, {24'h0, 4'h8, cap_mode[i]});
      n = 0;
      run <= 1'b1;
      repeat (512) @(posedge mclk) n += (evt === 1'b1);
      run <= 1'b0;
      repeat (24) @(posedge mclk) n += (evt === 1'b1);
      chk(34'(n), 34'(cap_cnt[i]));
    end
    wr(`CCP_OFF_CONTROL, 32'h0);
    rd(`CCP_OFF_STATUS, 8'h01);
    wr(`CCP_OFF_STATUS, 32'h0001);
    rd(`CCP_OFF_STATUS, 8'h00);
    final_report();
  end
endmodule : ccp_pwm_capture_compare_unit_tb
